/* File: pkt_check_pkg.sv */
// Constants and helper functions for the packet header and payload checker
package pkt_check_pkg;

  // Header parity coverage, one 24-bit mask per parity bit
  localparam logic [23:0] PAR_MASK0 = 24'hf12cb7;
  localparam logic [23:0] PAR_MASK1 = 24'hf2555b;
  localparam logic [23:0] PAR_MASK2 = 24'h749a6d;
  localparam logic [23:0] PAR_MASK3 = 24'hb8e38e;
  localparam logic [23:0] PAR_MASK4 = 24'hdf03f0;
  localparam logic [23:0] PAR_MASK5 = 24'heffc00;

  // Field positions inside the 24 header bits
  localparam int CHAN_LSB = 6;
  localparam int TYPE_LSB = 0;
  localparam int COUNT_LSB = 8;

  // Header byte count less one, and index of the header parity byte
  localparam logic [1:0] HDR_LAST = 2'h3;
  localparam logic [1:0] HDR_PARITY_IDX = 2'h3;

  // Checksum preset at the start of each payload
  localparam logic [15:0] CRC_PRESET = 16'hffff;

  // Low nibbles of the type code that mark a long packet
  localparam logic [3:0] LONG_NIB_A = 4'h9;
  localparam logic [3:0] LONG_NIB_B = 4'he;

  // Type code of the end-of-transmission packet
  localparam logic [5:0] EOT_TYPE = 6'h08;

  // Reset values of the result registers
  localparam logic [23:0] HDR_RESET = 24'h000000;
  localparam logic [7:0] SYN_RESET = 8'h00;

  function automatic logic [5:0] header_parity(input logic [23:0] hdr);
    header_parity = {^(hdr & PAR_MASK5), ^(hdr & PAR_MASK4), ^(hdr & PAR_MASK3),
                     ^(hdr & PAR_MASK2), ^(hdr & PAR_MASK1), ^(hdr & PAR_MASK0)};
  endfunction : header_parity

  // Syndrome that a single flipped header bit produces
  function automatic logic [7:0] bit_syndrome(input int idx);
    bit_syndrome = {2'b00, PAR_MASK5[idx], PAR_MASK4[idx], PAR_MASK3[idx],
                    PAR_MASK2[idx], PAR_MASK1[idx], PAR_MASK0[idx]};
  endfunction : bit_syndrome

  function automatic logic is_long_type(input logic [5:0] code);
    is_long_type = (code[3:0] == LONG_NIB_A) || (code[3:0] == LONG_NIB_B);
  endfunction : is_long_type

  // One byte into x^16+x^12+x^5+1, most significant bit first, shifting right
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    logic fb;
    c = crc;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = data[i] ^ c[0];
      c = {fb, c[15:12], c[11] ^ fb, c[10:5], c[4] ^ fb, c[3:1]};
    end
    crc_byte = c;
  endfunction : crc_byte

endpackage : pkt_check_pkg

/* File: pkt_header_check.sv */
// Receive-side packet header parity and payload checksum checker
//
// Overview of operation
// RQ1: First packet byte splits into channel tag (bits 7:6) and type code (5:0).
// RQ2: Type code picks short or long; long packets use the length field.
// RQ3: After a packet ends, next byte is a new header or burst end.
// RQ4: Each packet in a burst carries its own channel tag, four possible.
// RQ5: The host always sends a parity byte with every header.
// RQ6: Header parity serves received headers and headers sent back to host.
// RQ7: Upper two parity bits are always zero.
// RQ8: Each parity bit is XOR of a fixed subset of header bits.
// RQ9: Recomputed parity XOR received parity forms an 8-bit syndrome.
// RQ10: Zero syndrome means clean header; nonzero means corruption.
// RQ11: Syndrome matching a single-bit value flips that header bit.
// RQ12: Nonzero syndrome matching no single-bit value flags uncorrectable error.
// RQ13: Long packet ends with checksum over payload only, right after payload.
// RQ14: Checksum is 16-bit CRC with polynomial x^16+x^12+x^5+1.
// RQ15: Checksum preset to all ones before the first payload bit.
// RQ16: Each payload byte enters the checksum most significant bit first.
// RQ17: Long header is identifier, 16-bit payload length, parity byte.
// RQ18: Short packet is exactly four bytes with no trailer.
// RQ19: Multi-byte fields arrive low byte first.
// RQ20: Payload is good only when computed and received checksums match.
// RQ21: Header bits 7:0 identifier, 15:8 next byte, 23:16 the byte after.
// RQ22: Separate indications for corrected, uncorrectable and checksum errors per packet.
`timescale 1ns/1ps

module pkt_header_check
  import pkt_check_pkg::*;
(
  // System clock and reset
  input wire logic CLK,
  input wire logic NRST,

  // Link byte stream, on the link clock
  input wire logic LINK_CLK,
  input wire logic LINK_ACTIVE,
  input wire logic LINK_VALID,
  input wire logic [7:0] LINK_BYTE,

  // Header to be sent back to the host
  input wire logic [23:0] TX_HEADER,
  output logic [7:0] TX_PARITY,

  // Per-packet results, system clock
  output logic PKT_DONE,
  output logic [1:0] CHANNEL_TAG,
  output logic [5:0] PACKET_TYPE_CODE,
  output logic [15:0] PKT_WORD_COUNT,
  output logic PKT_LONG,
  output logic PKT_END_OF_BURST,
  output logic [7:0] PARITY_SYNDROME,
  output logic HDR_CORRECTED,
  output logic HDR_UNCORRECTABLE,
  output logic CRC_MISMATCH
);

  typedef enum logic [1:0] {ST_HEADER, ST_PAYLOAD, ST_TRAILER} rx_state_e;

  // Link-side reset: asserts at once, releases on the link clock
  logic [1:0] lrst_sync_reg;
  logic lrst_n;

  always_ff @(posedge LINK_CLK or negedge NRST) begin
    if (!NRST) begin
      lrst_sync_reg <= 2'b00;
    end else begin
      lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
    end
  end

  assign lrst_n = lrst_sync_reg[1];

  // Link-side state
  rx_state_e state_reg, state_next;
  logic [1:0] hdr_cnt_reg, hdr_cnt_next;
  logic [23:0] hdr_reg, hdr_next;
  logic [15:0] remain_reg, remain_next;
  logic [15:0] crc_reg, crc_next;
  logic [7:0] trl_lo_reg, trl_lo_next;
  logic trl_cnt_reg, trl_cnt_next;

  // Link-side results, held until the parity byte of the next header
  logic [23:0] res_hdr_reg, res_hdr_next;
  logic [7:0] res_syn_reg, res_syn_next;
  logic res_fixed_reg, res_fixed_next;
  logic res_bad_reg, res_bad_next;
  logic res_long_reg, res_long_next;
  logic res_crc_bad_reg, res_crc_bad_next;
  logic res_tgl_reg, res_tgl_next;

  // Header decode
  logic take;
  logic hdr_last_byte;
  logic [7:0] local_parity;
  logic [7:0] parity_syndrome;
  logic [23:0] flip_mask;
  logic [23:0] hdr_fixed;
  logic single_err;
  logic multi_err;
  logic fixed_long;
  logic [15:0] fixed_count;
  logic [15:0] payload_crc;
  logic [15:0] trailer_word;
  logic publish;

  assign take = LINK_VALID & LINK_ACTIVE;
  assign hdr_last_byte = (hdr_cnt_reg == HDR_PARITY_IDX);

  assign local_parity = {2'b00, header_parity(hdr_reg)}; // RQ7 RQ8
  assign parity_syndrome = local_parity ^ LINK_BYTE; // RQ9

  // Single-bit syndrome lookup, one comparator per header bit
  for (genvar i = 0; i < 24; i++) begin : g_flip
    assign flip_mask[i] = (parity_syndrome == bit_syndrome(i)); // RQ11
  end

  assign hdr_fixed = hdr_reg ^ flip_mask; // RQ11
  assign single_err = |flip_mask;
  assign multi_err = (parity_syndrome != 8'h00) && !single_err; // RQ10 RQ12

  // A header that cannot be trusted is treated as short, so hunting resumes
  assign fixed_long = is_long_type(hdr_fixed[TYPE_LSB +: 6]) && !multi_err; // RQ2
  assign fixed_count = hdr_fixed[COUNT_LSB +: 16]; // RQ17 RQ19 RQ21

  assign payload_crc = crc_byte(crc_reg, LINK_BYTE); // RQ14 RQ16
  assign trailer_word = {LINK_BYTE, trl_lo_reg}; // RQ19

  always_comb begin
    state_next = state_reg;
    hdr_cnt_next = hdr_cnt_reg;
    hdr_next = hdr_reg;
    remain_next = remain_reg;
    crc_next = crc_reg;
    trl_lo_next = trl_lo_reg;
    trl_cnt_next = trl_cnt_reg;
    res_hdr_next = res_hdr_reg;
    res_syn_next = res_syn_reg;
    res_fixed_next = res_fixed_reg;
    res_bad_next = res_bad_reg;
    res_long_next = res_long_reg;
    res_crc_bad_next = res_crc_bad_reg;
    publish = 1'b0;
    case (state_reg)
      ST_HEADER: begin
        if (take && hdr_last_byte) begin
          hdr_cnt_next = 2'h0;
          res_hdr_next = hdr_fixed;
          res_syn_next = parity_syndrome;
          res_fixed_next = single_err;
          res_bad_next = multi_err;
          res_long_next = fixed_long;
          res_crc_bad_next = 1'b0;
          if (fixed_long) begin
            remain_next = fixed_count; // RQ2
            crc_next = CRC_PRESET; // RQ15
            trl_cnt_next = 1'b0;
            state_next = (fixed_count == 16'h0000) ? ST_TRAILER : ST_PAYLOAD; // RQ13
          end else begin
            publish = 1'b1; // RQ18
          end
        end else if (take) begin
          hdr_next[8 * hdr_cnt_reg +: 8] = LINK_BYTE; // RQ1 RQ21
          hdr_cnt_next = 2'(hdr_cnt_reg + 2'h1);
        end
      end
      ST_PAYLOAD: begin
        if (take) begin
          crc_next = payload_crc; // RQ14 RQ16
          remain_next = 16'(remain_reg - 16'h0001);
          if (remain_reg == 16'h0001) begin
            state_next = ST_TRAILER; // RQ13
          end
        end
      end
      ST_TRAILER: begin
        if (take && !trl_cnt_reg) begin
          trl_lo_next = LINK_BYTE;
          trl_cnt_next = 1'b1;
        end else if (take) begin
          res_crc_bad_next = (trailer_word != crc_reg); // RQ20
          publish = 1'b1;
          state_next = ST_HEADER; // RQ3
        end
      end
      default: begin
        state_next = ST_HEADER;
      end
    endcase
    // Burst end abandons any partial packet
    if (!LINK_ACTIVE) begin
      state_next = ST_HEADER; // RQ3
      hdr_cnt_next = 2'h0;
      trl_cnt_next = 1'b0;
    end
  end

  assign res_tgl_next = res_tgl_reg ^ publish;

  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      state_reg <= ST_HEADER;
      hdr_cnt_reg <= 2'h0;
      hdr_reg <= HDR_RESET;
      remain_reg <= 16'h0000;
      crc_reg <= CRC_PRESET;
      trl_lo_reg <= 8'h00;
      trl_cnt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hdr_cnt_reg <= hdr_cnt_next;
      hdr_reg <= hdr_next;
      remain_reg <= remain_next;
      crc_reg <= crc_next;
      trl_lo_reg <= trl_lo_next;
      trl_cnt_reg <= trl_cnt_next;
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      res_hdr_reg <= HDR_RESET;
      res_syn_reg <= SYN_RESET;
      res_fixed_reg <= 1'b0;
      res_bad_reg <= 1'b0;
      res_long_reg <= 1'b0;
      res_crc_bad_reg <= 1'b0;
      res_tgl_reg <= 1'b0;
    end else begin
      res_hdr_reg <= res_hdr_next;
      res_syn_reg <= res_syn_next;
      res_fixed_reg <= res_fixed_next;
      res_bad_reg <= res_bad_next;
      res_long_reg <= res_long_next;
      res_crc_bad_reg <= res_crc_bad_next;
      res_tgl_reg <= res_tgl_next;
    end
  end

  // Toggle crossing; results stay still for at least four link bytes,
  // far longer than the three system cycles the toggle needs to land
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic new_result;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= res_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  assign new_result = tgl_s2_reg ^ tgl_s3_reg;

  // System-side outputs
  logic done_reg;
  logic [23:0] out_hdr_reg;
  logic [7:0] out_syn_reg;
  logic out_long_reg;
  logic out_fixed_reg;
  logic out_bad_reg;
  logic out_crc_bad_reg;
  logic out_eob_reg;
  logic [7:0] tx_parity_reg;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      done_reg <= 1'b0;
      out_hdr_reg <= HDR_RESET;
      out_syn_reg <= SYN_RESET;
      out_long_reg <= 1'b0;
      out_fixed_reg <= 1'b0;
      out_bad_reg <= 1'b0;
      out_crc_bad_reg <= 1'b0;
      out_eob_reg <= 1'b0;
    end else begin
      done_reg <= new_result; // RQ22
      if (new_result) begin
        out_hdr_reg <= res_hdr_reg; // RQ4
        out_syn_reg <= res_syn_reg;
        out_long_reg <= res_long_reg;
        out_fixed_reg <= res_fixed_reg; // RQ22
        out_bad_reg <= res_bad_reg; // RQ22
        out_crc_bad_reg <= res_crc_bad_reg; // RQ22
        // Decoded before the flop so the port has no logic after it
        out_eob_reg <= (res_hdr_reg[TYPE_LSB +: 6] == EOT_TYPE); // RQ3
      end
    end
  end

  // Parity for headers going back to the host
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_parity_reg <= SYN_RESET;
    end else begin
      tx_parity_reg <= {2'b00, header_parity(TX_HEADER)}; // RQ6 RQ7
    end
  end

  assign PKT_DONE = done_reg;
  assign CHANNEL_TAG = out_hdr_reg[CHAN_LSB +: 2];
  assign PACKET_TYPE_CODE = out_hdr_reg[TYPE_LSB +: 6];
  assign PKT_WORD_COUNT = out_hdr_reg[COUNT_LSB +: 16];
  assign PKT_LONG = out_long_reg;
  assign PKT_END_OF_BURST = out_eob_reg;
  assign PARITY_SYNDROME = out_syn_reg;
  assign HDR_CORRECTED = out_fixed_reg;
  assign HDR_UNCORRECTABLE = out_bad_reg;
  assign CRC_MISMATCH = out_crc_bad_reg;
  assign TX_PARITY = tx_parity_reg;

endmodule : pkt_header_check

/* File: pkt_header_check_asserts.sv */
// Port checks for the packet header checker
`timescale 1ns/1ps
module pkt_header_check_asserts
  import pkt_check_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Watched ports
  input wire logic [23:0] TX_HEADER,
  input wire logic [7:0] TX_PARITY,
  input wire logic PKT_DONE,
  input wire logic [1:0] CHANNEL_TAG,
  input wire logic [5:0] PACKET_TYPE_CODE,
  input wire logic [15:0] PKT_WORD_COUNT,
  input wire logic PKT_LONG,
  input wire logic PKT_END_OF_BURST,
  input wire logic [7:0] PARITY_SYNDROME,
  input wire logic HDR_CORRECTED,
  input wire logic HDR_UNCORRECTABLE,
  input wire logic CRC_MISMATCH
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic [23:0] h_reg;
  wire logic [5:0] exp_par;
  always_ff @(posedge CLK) h_reg <= TX_HEADER;
  assign exp_par = {^(h_reg & PAR_MASK5), ^(h_reg & PAR_MASK4), ^(h_reg & PAR_MASK3),
                    ^(h_reg & PAR_MASK2), ^(h_reg & PAR_MASK1), ^(h_reg & PAR_MASK0)};
  // Packets are at least four link bytes apart, far more than eight cycles
  sequence s_quiet;
    !PKT_DONE [*8];
  endsequence
  sequence s_news;
    $changed({CHANNEL_TAG, PACKET_TYPE_CODE, PKT_WORD_COUNT, PARITY_SYNDROME});
  endsequence
  property p_tx_par; $past(NRST) |-> TX_PARITY[5:0] == exp_par; endproperty
  property p_tx_top; TX_PARITY[7:6] == 2'h0; endproperty
  property p_done; PKT_DONE |=> s_quiet; endproperty
  property p_hold; s_news |-> PKT_DONE; endproperty
  property p_clean; PKT_DONE && PARITY_SYNDROME == 8'h00 |-> !HDR_CORRECTED && !HDR_UNCORRECTABLE; endproperty
  property p_dirty; PKT_DONE && PARITY_SYNDROME != 8'h00 |-> HDR_CORRECTED != HDR_UNCORRECTABLE; endproperty
  property p_fix; PKT_DONE && HDR_CORRECTED |-> PARITY_SYNDROME[7:6] == 2'h0 && $countones(PARITY_SYNDROME) > 2;
  endproperty
  property p_long;
    PKT_DONE |-> PKT_LONG == ((PACKET_TYPE_CODE[3:0] inside {4'h9, 4'he}) && !HDR_UNCORRECTABLE);
  endproperty
  property p_short; PKT_DONE && !PKT_LONG |-> !CRC_MISMATCH; endproperty
  property p_eob; PKT_END_OF_BURST == (PACKET_TYPE_CODE == 6'h08); endproperty
  a_tx_par: assert property (p_tx_par) else $error("return parity wrong");
  a_tx_top: assert property (p_tx_top) else $error("return parity top bits set");
  a_done: assert property (p_done) else $error("result strobe too long");
  a_hold: assert property (p_hold) else $error("result changed without strobe");
  a_clean: assert property (p_clean) else $error("error flag on clean header");
  a_dirty: assert property (p_dirty) else $error("bad header not flagged once");
  a_fix: assert property (p_fix) else $error("correction on impossible syndrome");
  a_long: assert property (p_long) else $error("long flag wrong");
  a_short: assert property (p_short) else $error("checksum flag on short packet");
  a_eob: assert property (p_eob) else $error("end of burst decode wrong");
endmodule : pkt_header_check_asserts

/* File: link_host.sv */
// Host model that sends packets on a gated link byte clock
`timescale 1ns/1ps
module link_host
  import pkt_check_pkg::*;
(
  // Link side
  output logic link_clk,
  output logic link_active,
  output logic link_valid,
  output logic [7:0] link_byte
);
  logic [7:0] q[$];
  initial begin
    link_clk = 1'b1;
    link_active = 1'b0;
    link_valid = 1'b0;
    link_byte = 8'h00;
  end
  // Clock stands high between bursts; data moves 1 ns after a rise
  task automatic cyc();
    #79 link_clk = 1'b0;
    #80 link_clk = 1'b1;
    #1;
  endtask : cyc
  function automatic logic [7:0] par(input logic [23:0] h);
    return {2'h0, ^(h & PAR_MASK5), ^(h & PAR_MASK4), ^(h & PAR_MASK3),
            ^(h & PAR_MASK2), ^(h & PAR_MASK1), ^(h & PAR_MASK0)};
  endfunction : par
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = {d[i] ^ c[0], c[15:12], c[11] ^ d[i] ^ c[0], c[10:5], c[4] ^ d[i] ^ c[0], c[3:1]};
    end
    return c;
  endfunction : crc
  // Flip spoils header and parity bits, bad spoils the trailer
  task automatic add(input logic [7:0] id, input logic [15:0] w, input logic [31:0] fl, input logic bad,
                     input logic [15:0] sd);
    logic [23:0] h;
    logic [15:0] c;
    logic [7:0] d;
    h = {w, id} ^ fl[23:0];
    c = 16'hffff;
    q.push_back(h[7:0]);
    q.push_back(h[15:8]);
    q.push_back(h[23:16]);
    q.push_back(par({w, id}) ^ fl[31:24]);
    if (id[3:0] == 4'h9 || id[3:0] == 4'he) begin
      for (int i = 0; i < w; i++) begin
        d = sd[7:0] ^ 8'(i * 37);
        c = crc(c, d);
        q.push_back(d);
      end
      q.push_back(c[7:0] ^ {7'h00, bad});
      q.push_back(c[15:8]);
    end
  endtask : add
  task automatic send(input int abort);
    #3;
    if (q.size() != 0) link_active = 1'b1;
    foreach (q[i]) begin
      if (i == abort) break;
      if (q[i][2:0] == 3'h5) begin
        link_valid = 1'b0;
        link_byte = ~link_byte;
        cyc();
      end
      link_valid = 1'b1;
      link_byte = q[i];
      cyc();
    end
    link_active = 1'b0;
    link_valid = 1'b0;
    link_byte = ~link_byte;
    cyc();
    q.delete();
  endtask : send
endmodule : link_host

/* File: pkt_header_check_test.sv */
// Self-checking bench for the packet header checker
`timescale 1ns/1ps
module pkt_header_check_test
  import pkt_check_pkg::*;
;
  localparam logic [5:0] TYPES [8] = '{6'h01, 6'h08, 6'h05, 6'h37, 6'h09, 6'h19, 6'h2e, 6'h39};
  logic clk = 1'b0;
  logic nrst = 1'b1;
  logic [23:0] tx_h = 24'h000000;
  logic link_clk, link_active, link_valid, done, lng, eob, cor, unc, crcm;
  logic [7:0] link_byte, tx_par, syn;
  logic [1:0] ch;
  logic [5:0] typ;
  logic [15:0] wc;
  logic [15:0] rnd = 16'h0033;
  int bad_count = 0;
  int n_tests = 0;
  logic [36:0] got[$], exp[$], msk[$];
  always #4 clk = ~clk;
  link_host i_host (.link_clk(link_clk), .link_active(link_active), .link_valid(link_valid), .link_byte(link_byte));
  pkt_header_check i_dut (.CLK(clk), .NRST(nrst), .LINK_CLK(link_clk), .LINK_ACTIVE(link_active),
    .LINK_VALID(link_valid), .LINK_BYTE(link_byte), .TX_HEADER(tx_h), .TX_PARITY(tx_par), .PKT_DONE(done),
    .CHANNEL_TAG(ch), .PACKET_TYPE_CODE(typ), .PKT_WORD_COUNT(wc), .PKT_LONG(lng), .PKT_END_OF_BURST(eob),
    .PARITY_SYNDROME(syn), .HDR_CORRECTED(cor), .HDR_UNCORRECTABLE(unc), .CRC_MISMATCH(crcm));
  // Mid-cycle capture keeps clear of the edge that moves the results
  always @(negedge clk) if (done === 1'b1) got.push_back({ch, typ, wc, lng, eob, syn, cor, unc, crcm});
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic check(input logic [36:0] g, input logic [36:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : check
  // Expected result; an uncorrectable header leaves only the long flag, syndrome and error flags meaningful
  task automatic pkt(input logic [7:0] id, input logic [15:0] w, input logic [31:0] fl, input logic bad);
    logic [7:0] s;
    logic u, lg;
    s = i_host.par({w, id} ^ fl[23:0]) ^ i_host.par({w, id}) ^ fl[31:24];
    u = s != 8'h00 && !($countones(fl) == 1 && fl[31:24] == 8'h00);
    lg = (id[3:0] == 4'h9 || id[3:0] == 4'he) && !u;
    exp.push_back({id, w, lg, id[5:0] == 6'h08, s, s != 8'h00 && !u, u, bad & lg});
    msk.push_back(u ? {24'h000000, 13'h17ff} : {37{1'b1}});
    i_host.add(id, w, fl, bad, rnd);
  endtask : pkt
  task automatic burst(input int abort);
    i_host.send(abort);
    repeat (8) @(posedge clk);
    #1;
    check(37'(got.size()), 37'(exp.size()), "result count");
    foreach (exp[i]) if (i < got.size()) check(got[i] & msk[i], exp[i] & msk[i], "packet result");
    got.delete();
    exp.delete();
    msk.delete();
  endtask : burst
  initial begin
    #400000;
    bad_count++;
    summarize();
  end
  initial begin
    logic [31:0] fl;
    logic lg;
    int kind;
    // Reset falls after time zero so the asynchronous resets see an edge
    #1 nrst = 1'b0;
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) i_host.send(0);
    pkt(8'h05, 16'h0010, 32'h0, 1'b0);
    pkt(8'h29, 16'h0001, 32'h0, 1'b0);
    pkt(8'hfe, 16'h0000, 32'h0, 1'b1);
    pkt(8'h45, 16'h0010, 32'h0000_0008, 1'b0);
    pkt(8'h85, 16'h0010, 32'h0000_0300, 1'b0);
    pkt(8'hc8, 16'h0000, 32'h0100_0000, 1'b0);
    burst(99);
    i_host.add(8'h39, 16'h1234, 32'h0, 1'b0, rnd);
    i_host.send(2);
    pkt(8'h48, 16'h0000, 32'h0, 1'b0);
    burst(99);
    repeat (14) begin
      repeat (1 + rnd[1:0]) begin
        rnd = lfsr(rnd);
        lg = rnd[5];
        kind = rnd[10:8];
        fl = kind == 4 ? 32'h1 << (rnd[15:11] % 24) : 32'h0;
        tx_h = {rnd, rnd[7:6], TYPES[rnd[5:3]]};
        rnd = lfsr(rnd);
        if (kind == 6 && !lg) fl = 32'h0000_0101 << rnd[12:8];
        pkt(tx_h[7:0], lg ? {13'h0000, rnd[2:0]} : rnd, fl, kind == 5);
        @(posedge clk);
        @(posedge clk);
        #1;
        check(37'(tx_par), 37'(i_host.par(tx_h)), "return parity");
      end
      burst(99);
    end
    summarize();
  end
endmodule : pkt_header_check_test
bind pkt_header_check pkt_header_check_asserts i_chk (.CLK(CLK), .NRST(NRST), .TX_HEADER(TX_HEADER),
  .TX_PARITY(TX_PARITY), .PKT_DONE(PKT_DONE), .CHANNEL_TAG(CHANNEL_TAG), .PACKET_TYPE_CODE(PACKET_TYPE_CODE),
  .PKT_WORD_COUNT(PKT_WORD_COUNT), .PKT_LONG(PKT_LONG), .PKT_END_OF_BURST(PKT_END_OF_BURST),
  .PARITY_SYNDROME(PARITY_SYNDROME), .HDR_CORRECTED(HDR_CORRECTED), .HDR_UNCORRECTABLE(HDR_UNCORRECTABLE),
  .CRC_MISMATCH(CRC_MISMATCH));
